// ==== hw/hts_host_ctrl.sv ====
// host end: wishbone-controlled two-wire controller for the sensor
`timescale 1ns/1ns
module hts_host_ctrl #(
  parameter int unsigned QTR_CYC = hts_pkg::I2C_QTR_CYC,
  parameter int unsigned PWRUP_WAIT = hts_pkg::PWRUP_WAIT_CYC,
  parameter int unsigned CONV_WAIT = hts_pkg::CONV_WAIT_CYC,
  parameter int unsigned SETTLE_WAIT = hts_pkg::SETTLE_WAIT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  hts_if.host bus
);
  import hts_pkg::*;

  hts_host_state_type state;
  logic [1:0] sda_sync;
  logic [31:0] qcnt;
  logic [1:0] q;
  logic [3:0] bi;
  logic [2:0] bidx;
  logic [2:0] nbytes;
  logic is_read;
  logic scl_lvl;
  logic sda_lvl;
  logic [7:0] rxsh;
  logic [15:0] raw_temp;
  logic [15:0] raw_hum;
  logic nack;
  logic [31:0] hold;
  logic pend;
  logic pend_read;
  logic pend_cfg;
  logic [7:0] pend_ptr;
  logic [15:0] pend_cfgdata;
  logic launch;
  logic tick;
  logic rd_byte;
  logic [7:0] txb;
  logic [7:0] txs;
  logic bit_out;
  logic [31:0] temp_centi;
  logic [31:0] hum_centi;
  logic wb_req;

  assign bus.scl_host_out = 1'b0;
  assign bus.sda_host_out = 1'b0;
  assign bus.scl_host_oe = ~scl_lvl;
  assign bus.sda_host_oe = ~sda_lvl;
  assign tick = (qcnt == 32'h0);
  assign launch = pend && (hold == 32'h0) && (state == HS_IDLE); // see R5 R8 R13
  assign rd_byte = is_read && (bidx != 3'h0);
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    case (bidx)
      3'h0: txb = is_read ? ADDR_RD_BYTE : ADDR_WR_BYTE; // see R11
      3'h1: txb = pend_ptr; // see R6
      3'h2: txb = pend_cfgdata[15:8];
      default: txb = pend_cfgdata[7:0];
    endcase
    txs = txb << bi[2:0];
    if (bi == 4'h8) begin
      bit_out = rd_byte ? (bidx == nbytes - 3'h1) : 1'b1; // see R14
    end else begin
      bit_out = rd_byte ? 1'b1 : txs[7];
    end
  end

  // ****************************************
  // result scaling
  // ****************************************
  always_comb begin
    temp_centi = ((32'(raw_temp) * TEMP_SPAN_CENTI) >> SCALE_SHIFT) - TEMP_OFFS_CENTI; // see R15
    hum_centi = (32'(raw_hum) * HUM_SPAN_CENTI) >> SCALE_SHIFT; // see R16
  end

  // ****************************************
  // wishbone slave and command latch
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      pend <= 1'b0;
      pend_read <= 1'b0;
      pend_cfg <= 1'b0;
      pend_ptr <= PTR_TEMP;
      pend_cfgdata <= CFG_RESET;
    end else begin
      wb_ack_o <= wb_req;
      if (launch) begin
        pend <= 1'b0;
      end
      if (wb_req && wb_we_i && wb_adr_i == WB_CTRL && wb_sel_i[0] && !pend &&
          state == HS_IDLE) begin
        pend <= wb_dat_i[CTRL_TRIG_BIT] | wb_dat_i[CTRL_READ_BIT] | wb_dat_i[CTRL_CFG_BIT];
        pend_read <= wb_dat_i[CTRL_READ_BIT];
        pend_cfg <= wb_dat_i[CTRL_CFG_BIT];
        pend_ptr <= wb_dat_i[CTRL_PTR_LO+7:CTRL_PTR_LO];
        pend_cfgdata <= wb_dat_i[CTRL_CFG_LO+15:CTRL_CFG_LO];
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          WB_STATUS: wb_dat_o <= {29'h0, hold != 32'h0, nack, pend || state != HS_IDLE};
          WB_RAW: wb_dat_o <= {raw_temp, raw_hum};
          WB_TEMP: wb_dat_o <= temp_centi;
          WB_HUM: wb_dat_o <= hum_centi;
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // wait timer between transactions
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 32'(PWRUP_WAIT); // see R5
    end else if (state == HS_STOP && tick && q == 2'h3) begin
      if (is_read) begin
        hold <= 32'(SETTLE_WAIT); // see R8
      end else if (!nack && (pend_ptr == PTR_TEMP || pend_ptr == PTR_HUM)) begin
        hold <= 32'(CONV_WAIT); // see R13
      end
    end else if (hold != 32'h0) begin
      hold <= hold - 32'h1;
    end
  end

  // ****************************************
  // bit engine
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_sync <= 2'h3;
      state <= HS_IDLE;
      qcnt <= 32'h0;
      q <= 2'h0;
      bi <= 4'h0;
      bidx <= 3'h0;
      nbytes <= 3'h0;
      is_read <= 1'b0;
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      rxsh <= 8'h00;
      raw_temp <= RESULT_RESET;
      raw_hum <= RESULT_RESET;
      nack <= 1'b0;
    end else begin
      sda_sync <= {sda_sync[0], bus.sda};
      qcnt <= tick ? 32'(QTR_CYC - 1) : qcnt - 32'h1;
      if (launch) begin
        state <= HS_START;
        q <= 2'h0;
        bi <= 4'h0;
        bidx <= 3'h0;
        nack <= 1'b0;
        is_read <= pend_read;
        nbytes <= pend_read ? 3'h5 : (pend_cfg ? 3'h4 : 3'h2); // see R14
      end else if (tick && state != HS_IDLE) begin
        q <= q + 2'h1;
        case (state)
          HS_START: begin
            if (q == 2'h1) begin
              sda_lvl <= 1'b0;
            end else if (q == 2'h3) begin
              scl_lvl <= 1'b0;
              state <= HS_BITS;
            end
          end
          HS_BITS: begin
            if (q == 2'h0) begin
              sda_lvl <= bit_out;
            end else if (q == 2'h1) begin
              scl_lvl <= 1'b1;
            end else if (q == 2'h2) begin
              if (bi != 4'h8 && rd_byte) begin
                rxsh <= {rxsh[6:0], sda_sync[1]};
              end else if (bi == 4'h8 && !rd_byte && sda_sync[1]) begin
                nack <= 1'b1; // see R12
              end
            end else begin
              scl_lvl <= 1'b0;
              if (bi == 4'h8) begin
                bi <= 4'h0;
                case (bidx)
                  3'h1: raw_temp[15:8] <= rd_byte ? rxsh : raw_temp[15:8];
                  3'h2: raw_temp[7:0] <= rd_byte ? rxsh : raw_temp[7:0];
                  3'h3: raw_hum[15:8] <= rd_byte ? rxsh : raw_hum[15:8];
                  3'h4: raw_hum[7:0] <= rd_byte ? rxsh : raw_hum[7:0];
                  default: raw_temp <= raw_temp;
                endcase
                if (nack || bidx == nbytes - 3'h1) begin
                  state <= HS_STOP;
                end else begin
                  bidx <= bidx + 3'h1;
                end
              end else begin
                bi <= bi + 4'h1;
              end
            end
          end
          HS_STOP: begin
            if (q == 2'h0) begin
              sda_lvl <= 1'b0;
            end else if (q == 2'h1) begin
              scl_lvl <= 1'b1;
            end else if (q == 2'h2) begin
              sda_lvl <= 1'b1;
            end else begin
              state <= HS_IDLE;
            end
          end
          default: state <= HS_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== hw/hts_sensor_device.sv ====
// sensor end: two-wire target, result registers and conversion timer
//
// Overview of operation
// R1: temp result at 0x00, humidity 0x01
// R2: result upper 14 bits, two lsbs zero
// R3: humidity conversion 2.50/3.85/6.50 ms
// R4: temperature conversion 3.65/6.35 ms
// R5: host waits 15 ms after power-up
// R6: pointer write to result starts conversion
// R7: pointer auto-increments during multi-byte read
// R8: host waits one second between readings
// R9: write during conversion aborts and restarts
// R10: read during conversion is not acknowledged
// R11: target address 0x40, write byte 0x80
// R12: address and pointer bytes acknowledged
// R13: host waits both conversion times before reading
// R14: four bytes, msb first, last not acknowledged
// R15: temperature = raw/65536*165 - 40
// R16: humidity = raw/65536*100
// R17: mode bit selects single or sequenced conversion
// R18: config resolution bits 10 and 9:8
// R19: result kept until next conversion completes
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
module hts_sensor_device #(
  parameter int unsigned CONV_HUM8 = hts_pkg::CONV_HUM8_CYC,
  parameter int unsigned CONV_HUM11 = hts_pkg::CONV_HUM11_CYC,
  parameter int unsigned CONV_HUM14 = hts_pkg::CONV_HUM14_CYC,
  parameter int unsigned CONV_TEMP11 = hts_pkg::CONV_TEMP11_CYC,
  parameter int unsigned CONV_TEMP14 = hts_pkg::CONV_TEMP14_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  hts_if.device bus,
  input wire logic [hts_pkg::SAMPLE_W-1:0] temp_sample,
  input wire logic [hts_pkg::SAMPLE_W-1:0] humidity_sample,
  output logic conversion_busy
);
  import hts_pkg::*;
  // ****************************************
  // pin synchronisers and line events
  // ****************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl_s;
  logic sda_s;
  logic line_start;
  logic line_stop;
  logic scl_rise;
  logic scl_fall;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus.scl};
      sda_sync <= {sda_sync[0], bus.sda};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign line_start = scl_s & scl_prev & sda_prev & ~sda_s;
  assign line_stop = scl_s & scl_prev & ~sda_prev & sda_s;
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  // ****************************************
  // registers
  // ****************************************
  hts_dev_state_type state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic [7:0] ptr;
  logic [1:0] wcount;
  logic [7:0] cfg_hi;
  logic [15:0] cfg;
  logic rd_lo;
  logic rw;
  logic mack;
  logic sda_oe;
  logic start_conv;
  logic [15:0] temp_result;
  logic [15:0] humidity_result;
  logic conv_temp;
  logic conv_seq;
  logic [31:0] conv_cnt;
  logic conv_done;
  logic [15:0] rd_word;
  logic [7:0] cur_byte;
  logic start_temp;
  assign bus.sda_dev_out = 1'b0;
  assign bus.sda_dev_oe = sda_oe;
  assign conversion_busy = conv_temp | conv_seq | (conv_cnt != 32'h0);
  // ****************************************
  // read data selection
  // ****************************************
  always_comb begin
    case (ptr)
      PTR_TEMP: rd_word = temp_result; // see R1
      PTR_HUM: rd_word = humidity_result; // see R1
      PTR_CONFIG: rd_word = cfg;
      default: rd_word = RESULT_RESET;
    endcase
    cur_byte = rd_lo ? rd_word[7:0] : rd_word[15:8]; // see R14
  end
  // ****************************************
  // conversion timing
  // ****************************************
  function automatic logic [31:0] conv_time(input logic is_temp, input logic [15:0] c);
    logic [31:0] t;
    t = 32'(CONV_HUM14);
    if (is_temp) begin
      t = c[CFG_TEMP_RESOLUTION_SEL_BIT] ? 32'(CONV_TEMP11) : 32'(CONV_TEMP14); // see R4 R18
    end else if (c[CFG_HUMIDITY_RESOLUTION_SEL_LO+1:CFG_HUMIDITY_RESOLUTION_SEL_LO] == HUMIDITY_RESOLUTION_SEL_11) begin
      t = 32'(CONV_HUM11); // see R3 R18
    end else if (c[CFG_HUMIDITY_RESOLUTION_SEL_LO+1:CFG_HUMIDITY_RESOLUTION_SEL_LO] == HUMIDITY_RESOLUTION_SEL_8) begin
      t = 32'(CONV_HUM8); // see R3 R18
    end
    return t;
  endfunction
  assign start_temp = cfg[CFG_MODE_BIT] | (ptr == PTR_TEMP); // see R17
  assign conv_done = (conv_cnt == 32'h1) & ~start_conv;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt <= 32'h0;
      conv_temp <= 1'b0;
      conv_seq <= 1'b0;
    end else if (start_conv) begin
      conv_cnt <= conv_time(start_temp, cfg); // see R6 R9
      conv_temp <= start_temp;
      conv_seq <= cfg[CFG_MODE_BIT]; // see R17
    end else if (conv_done) begin
      conv_cnt <= (conv_temp && conv_seq) ? conv_time(1'b0, cfg) : 32'h0; // see R17
      conv_temp <= 1'b0;
      conv_seq <= 1'b0;
    end else if (conv_cnt != 32'h0) begin
      conv_cnt <= conv_cnt - 32'h1;
    end
  end
  // results change only when a conversion completes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      temp_result <= RESULT_RESET;
      humidity_result <= RESULT_RESET;
    end else if (conv_done) begin
      if (conv_temp) begin
        temp_result <= {temp_sample, RESULT_PAD}; // see R2 R19
      end else begin
        humidity_result <= {humidity_sample, RESULT_PAD}; // see R2 R19
      end
    end
  end
  // ****************************************
  // two-wire target
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= DS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      ptr <= PTR_TEMP;
      wcount <= 2'h0;
      cfg_hi <= 8'h00;
      cfg <= CFG_RESET;
      rd_lo <= 1'b0;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_oe <= 1'b0;
      start_conv <= 1'b0;
    end else begin
      start_conv <= 1'b0;
      if (line_start) begin
        state <= DS_ADDR;
        // start's own clock fall wraps this to zero before the first bit
        bitcnt <= 4'hf;
        sda_oe <= 1'b0;
      end else if (line_stop) begin
        state <= DS_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == DS_ADDR || state == DS_WRITE) begin
          if (bitcnt != 4'h8) begin
            shreg <= {shreg[6:0], sda_s};
          end
        end else if (state == DS_READ && bitcnt == 4'h8) begin
          mack <= ~sda_s; // see R14
        end
      end else if (scl_fall) begin
        case (state)
          DS_ADDR: begin
            if (bitcnt == 4'h7) begin
              if (shreg[7:1] == DEV_ADDR && (!shreg[0] || !conversion_busy)) begin // see R10 R11
                sda_oe <= 1'b1; // see R12
                rw <= shreg[0];
                bitcnt <= 4'h8;
              end else begin
                state <= DS_IDLE;
              end
            end else if (bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              wcount <= 2'h0;
              if (rw) begin
                state <= DS_READ;
                txsh <= cur_byte << 1;
                sda_oe <= ~cur_byte[7]; // see R14
              end else begin
                state <= DS_WRITE;
                sda_oe <= 1'b0;
              end
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
          DS_WRITE: begin
            if (bitcnt == 4'h7) begin
              sda_oe <= 1'b1; // see R12
              bitcnt <= 4'h8;
              if (wcount == 2'h0) begin
                ptr <= shreg;
                rd_lo <= 1'b0;
                start_conv <= (shreg == PTR_TEMP) || (shreg == PTR_HUM); // see R6 R9
              end else if (wcount == 2'h1) begin
                cfg_hi <= shreg;
              end else if (ptr == PTR_CONFIG && wcount == 2'h2) begin
                cfg <= {cfg_hi, shreg} & CFG_WMASK; // see R18
              end
              if (wcount != 2'h3) begin
                wcount <= wcount + 2'h1;
              end
            end else if (bitcnt == 4'h8) begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end
          DS_READ: begin
            if (bitcnt == 4'h7) begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h8;
              rd_lo <= ~rd_lo;
              if (rd_lo) begin
                ptr <= ptr + 8'h01; // see R7
              end
            end else if (bitcnt == 4'h8) begin
              if (mack) begin
                bitcnt <= 4'h0;
                txsh <= cur_byte << 1;
                sda_oe <= ~cur_byte[7]; // see R7 R14
              end else begin
                state <= DS_IDLE;
              end
            end else begin
              bitcnt <= bitcnt + 4'h1;
              sda_oe <= ~txsh[7];
              txsh <= txsh << 1;
            end
          end
          default: sda_oe <= 1'b0;
        endcase
      end
    end
  end
endmodule

// ==== pkg/hts_if.sv ====
// open-drain two-wire link between host controller and sensor
`timescale 1ns/1ns
interface hts_if;
  logic scl_host_out;
  logic scl_host_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // pulled-up wires: low while any end enables its low driver
  assign scl = ~(scl_host_oe & ~scl_host_out);
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));
  modport host (output scl_host_out, scl_host_oe, sda_host_out, sda_host_oe, input scl, sda);
  modport device (output sda_dev_out, sda_dev_oe, input scl, sda);
endinterface

// ==== pkg/hts_pkg.sv ====
// shared constants and types of the humidity/temperature sensor link
package hts_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_HUM8_US = 2500;
  localparam int CONV_HUM11_US = 3850;
  localparam int CONV_HUM14_US = 6500;
  localparam int CONV_TEMP11_US = 3650;
  localparam int CONV_TEMP14_US = 6350;
  localparam int PWRUP_WAIT_US = 15000;
  localparam int SETTLE_WAIT_US = 1000000;
  localparam int CONV_WAIT_US = CONV_TEMP14_US + CONV_HUM14_US;
  localparam int I2C_QTR_NS = 2500;
  localparam int CONV_HUM8_CYC = CONV_HUM8_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_HUM11_CYC = CONV_HUM11_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_HUM14_CYC = CONV_HUM14_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_TEMP11_CYC = CONV_TEMP11_US * 1000 / CLK_PERIOD_NS;
  localparam int CONV_TEMP14_CYC = CONV_TEMP14_US * 1000 / CLK_PERIOD_NS;
  localparam int PWRUP_WAIT_CYC = (PWRUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_WAIT_CYC = (SETTLE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_WAIT_CYC = (CONV_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int I2C_QTR_CYC = (I2C_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // target address and register map
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic [7:0] ADDR_WR_BYTE = 8'h80;
  localparam logic [7:0] ADDR_RD_BYTE = 8'h81;
  localparam logic [7:0] PTR_TEMP = 8'h00;
  localparam logic [7:0] PTR_HUM = 8'h01;
  localparam logic [7:0] PTR_CONFIG = 8'h02;
  localparam int SAMPLE_W = 14;
  localparam logic [1:0] RESULT_PAD = 2'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h1000;
  localparam logic [15:0] CFG_WMASK = 16'h3700;
  localparam int CFG_MODE_BIT = 12;
  localparam int CFG_TEMP_RESOLUTION_SEL_BIT = 10;
  localparam int CFG_HUMIDITY_RESOLUTION_SEL_LO = 8;
  localparam logic [1:0] HUMIDITY_RESOLUTION_SEL_11 = 2'h1;
  localparam logic [1:0] HUMIDITY_RESOLUTION_SEL_8 = 2'h2;
  // ****************************************
  // host wishbone registers
  // ****************************************
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_STATUS = 8'h04;
  localparam logic [7:0] WB_RAW = 8'h08;
  localparam logic [7:0] WB_TEMP = 8'h0c;
  localparam logic [7:0] WB_HUM = 8'h10;
  localparam int CTRL_TRIG_BIT = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_CFG_BIT = 2;
  localparam int CTRL_PTR_LO = 8;
  localparam int CTRL_CFG_LO = 16;
  localparam logic [31:0] TEMP_SPAN_CENTI = 32'h0000_4074;
  localparam logic [31:0] TEMP_OFFS_CENTI = 32'h0000_0fa0;
  localparam logic [31:0] HUM_SPAN_CENTI = 32'h0000_2710;
  localparam int SCALE_SHIFT = 16;
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00, DS_ADDR = 2'b01, DS_WRITE = 2'b10, DS_READ = 2'b11
  } hts_dev_state_type;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_START = 2'b01, HS_BITS = 2'b10, HS_STOP = 2'b11
  } hts_host_state_type;
endpackage

// ==== test/hts_link_props.sv ====
// checker of the two-wire link between host controller and sensor
`timescale 1ns/1ns
module hts_link_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_host_out,
  input wire logic scl_host_oe,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  import hts_pkg::*;
  logic scl_d;
  logic sda_d;
  logic [5:0] bit_cnt;
  logic [7:0] addr_byte;
  // ****************************************
  // bit counter from each start
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= 6'h0;
    end else if (scl && scl_d && sda_d && !sda) begin
      bit_cnt <= 6'h0;
    end else if (scl && !scl_d) begin
      bit_cnt <= bit_cnt + 6'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_byte <= 8'h0;
    end else if (scl && !scl_d && bit_cnt < 6'h8) begin
      addr_byte <= {addr_byte[6:0], sda};
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence ack_slot(int n, logic [7:0] b);
    $rose(scl) && bit_cnt == n && addr_byte == b;
  endsequence
  dev_open_drain_a: assert property (sda_dev_out == 1'b0)
    else $error("device data driver not open drain");
  host_open_drain_a: assert property (!scl_host_out && !sda_host_out)
    else $error("host drivers not open drain");
  dev_sda_change_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device changed data while clock high");
  scl_high_time_a: assert property ($rose(scl) |=> scl [*7])
    else $error("clock high phase too short");
  scl_low_time_a: assert property ($fell(scl) |=> !scl [*7])
    else $error("clock low phase too short");
  start_by_host_a: assert property (scl && $fell(sda) |-> sda_host_oe)
    else $error("start not made by host");
  addr_ack_a: assert property (ack_slot(8, ADDR_WR_BYTE) |-> !sda)
    else $error("write address not acknowledged");
  ptr_ack_a: assert property (ack_slot(17, ADDR_WR_BYTE) |-> !sda)
    else $error("pointer byte not acknowledged");
  read_ack_a: assert property ((ack_slot(17, ADDR_RD_BYTE) or ack_slot(26, ADDR_RD_BYTE)
    or ack_slot(35, ADDR_RD_BYTE)) |-> !sda && sda_host_oe)
    else $error("host did not acknowledge read byte");
  last_nack_a: assert property (ack_slot(44, ADDR_RD_BYTE) |-> sda && !sda_dev_oe)
    else $error("last read byte acknowledged");
endmodule

// ==== test/humidity_temp_sensor_readout_tb.sv ====
// testbench: host controller and sensor joined over the two-wire link
`timescale 1ns/1ns
module humidity_temp_sensor_readout_tb;
  import hts_pkg::*;
  localparam int T14 = 350, H14 = 400, T11 = 250, H11 = 300, H8 = 200;
  localparam logic [15:0] CFG_TAB [5] = '{16'h0500, 16'h0500, 16'h0200, 16'h0000, 16'h0000};
  localparam logic [7:0] PTR_TAB [5] = '{PTR_TEMP, PTR_HUM, PTR_HUM, PTR_HUM, PTR_TEMP};
  localparam int EXP_TAB [5] = '{T11, H11, H8, H14, T14};
  logic ref_clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, conv_busy;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd, e;
  logic [13:0] temp_sample, hum_sample;
  int fail_count, compares, c;
  hts_if u_hts_if ();
  hts_sensor_device #(.CONV_HUM8(H8), .CONV_HUM11(H11), .CONV_HUM14(H14),
    .CONV_TEMP11(T11), .CONV_TEMP14(T14)) u_hts_sensor_device (.ref_clk(ref_clk),
    .reset_n(reset_n), .bus(u_hts_if), .temp_sample(temp_sample),
    .humidity_sample(hum_sample), .conversion_busy(conv_busy));
  hts_host_ctrl #(.QTR_CYC(8), .PWRUP_WAIT(100), .CONV_WAIT(800), .SETTLE_WAIT(200))
    u_hts_host_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus(u_hts_if));
  hts_link_props u_hts_link_props (.ref_clk(ref_clk), .reset_n(reset_n),
    .scl_host_out(u_hts_if.scl_host_out), .scl_host_oe(u_hts_if.scl_host_oe),
    .sda_host_out(u_hts_if.sda_host_out), .sda_host_oe(u_hts_if.sda_host_oe),
    .sda_dev_out(u_hts_if.sda_dev_out), .sda_dev_oe(u_hts_if.sda_dev_oe),
    .scl(u_hts_if.scl), .sda(u_hts_if.sda));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_cyc(input string name, input int exp, input int got);
    compares++;
    if (got < exp - 2 || got > exp + 2) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wb_access(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 5000) begin
      wb_access(1'b0, WB_STATUS, 32'h0);
      n++;
    end
    if (rd[0] !== 1'b0) fail_count++;
  endtask
  task automatic trigger(input logic [7:0] ptr, input logic [15:0] cfg,
    input logic [13:0] ts, input logic [13:0] hs);
    int n;
    n = 0;
    c = 0;
    wb_access(1'b1, WB_CTRL, {cfg, PTR_CONFIG, 8'h05});
    wait_idle();
    temp_sample <= ts;
    hum_sample <= hs;
    wb_access(1'b1, WB_CTRL, {16'h0, ptr, 8'h01});
    while (conv_busy !== 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    while (conv_busy === 1'b1) begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  task automatic read_all();
    wb_access(1'b1, WB_CTRL, 32'h2);
    wait_idle();
    check_val("status nack", 32'h0, rd & 32'h3);
    wb_access(1'b0, WB_RAW, 32'h0);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    reset_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
    wb_sel = 4'hf;
    temp_sample = 14'h0;
    hum_sample = 14'h0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    trigger(PTR_TEMP, 16'h1000, 14'h2a5c, 14'h1337);
    check_cyc("sequenced conversion", T14 + H14, c);
    read_all();
    check_val("raw words", {14'h2a5c, 2'h0, 14'h1337, 2'h0}, rd);
    wb_access(1'b0, WB_TEMP, 32'h0);
    e = ((32'ha970 * 32'h4074) >> 16) - 32'h0fa0;
    check_val("temperature", e, rd);
    wb_access(1'b0, WB_HUM, 32'h0);
    e = (32'h4cdc * 32'h2710) >> 16;
    check_val("humidity", e, rd);
    wb_access(1'b0, 8'h14, 32'h0);
    check_val("unmapped read", 32'h0, rd);
    for (int i = 0; i < 5; i++) begin
      trigger(PTR_TAB[i], CFG_TAB[i], 14'h0100 + 14'(i), 14'h0200 + 14'(i));
      check_cyc("single conversion", EXP_TAB[i], c);
    end
    read_all();
    check_val("kept results", {14'h0104, 2'h0, 14'h0203, 2'h0}, rd);
    results();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    results();
  end
endmodule
